/* logic/adcc_pkg.sv */
`default_nettype none
package adcc_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CHANNEL_CONTROL = 5'h00;
    localparam logic [4:0] OFS_FORMAT_CLOCK_REF = 5'h04;
    localparam logic [4:0] OFS_TRIGGER_SELECT = 5'h08;
    localparam logic [4:0] OFS_RESULT_HIGH = 5'h0c;
    localparam logic [4:0] OFS_RESULT_LOW = 5'h10;
    localparam logic [4:0] OFS_DONE_STATUS = 5'h14;
    // field positions
    localparam int POS_ENABLE = 0;
    localparam int POS_GO_BUSY = 1;
    localparam int POS_CHANNEL = 2;
    localparam int POS_POS_REF = 0;
    localparam int POS_CLOCK_SEL = 4;
    localparam int POS_JUSTIFY = 7;
    localparam int POS_TRIG_SEL = 4;
    localparam int POS_DONE_FLAG = 0;
    localparam int POS_IRQ_ENABLE = 1;
    localparam int POS_ACTIVE = 2;
    // reset values
    localparam logic [7:0] RST_CHANNEL_CONTROL = 8'h00;
    localparam logic [7:0] RST_FORMAT_CLOCK_REF = 8'h00;
    localparam logic [7:0] RST_TRIGGER_SELECT = 8'h00;
    localparam logic [7:0] RST_RESULT = 8'h00;
    // auto-trigger codes
    localparam logic [3:0] TRIG_NONE = 4'h0;
    localparam logic [3:0] TRIG_TIMER_0 = 4'h3;
    localparam logic [3:0] TRIG_TIMER_1 = 4'h4;
    localparam logic [3:0] TRIG_TIMER_2 = 4'h5;
    localparam logic [3:0] TRIG_COMPARATOR_1 = 4'h6;
    localparam logic [3:0] TRIG_LOGIC_CELL_1 = 4'h8;
    localparam logic [3:0] TRIG_LOGIC_CELL_2 = 4'h9;
    // channel codes
    localparam logic [4:0] CHAN_LAST_PIN = 5'h03;
    localparam logic [4:0] CHAN_TEMPERATURE = 5'h1d;
    localparam logic [4:0] CHAN_DAC = 5'h1e;
    localparam logic [4:0] CHAN_FIXED_REF = 5'h1f;
    // reference codes
    localparam logic [1:0] PREF_SUPPLY = 2'h0;
    localparam logic [1:0] PREF_EXT_PIN = 2'h2;
    // clock codes: low two bits 11 pick the dedicated rc clock
    localparam logic [1:0] CLK_RC_LOW = 2'h3;
    // timing
    localparam int CLK_HZ = 20_000_000;
    localparam int INSTR_CLKS_PER_CYCLE = 4;
    localparam int RC_START_DELAY_CLKS = INSTR_CLKS_PER_CYCLE;
    localparam int CONV_HALF_PERIODS = 23;
    localparam int SETUP_HALF_PERIODS = 3;
    localparam int RESULT_BITS = 10;

    typedef struct packed {
        logic timer_0;
        logic timer_1;
        logic timer_2;
        logic comparator_1_output;
        logic logic_cell_1;
        logic logic_cell_2;
    } adcc_trig_type;

    typedef struct packed {
        logic powered;
        logic channel_valid;
        logic [4:0] channel;
        logic ref_ext_pin;
        logic sampling;
        logic [9:0] trial;
    } adcc_analog_type;

    typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_CONV} adcc_state_type;
endpackage : adcc_pkg
`default_nettype wire

/* logic/adcc_tad_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_tad_gen #(
    parameter int DIV_W = 6
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [2:0] clock_sel,
    input wire logic rc_tick,
    output logic half_tick
);
    if (DIV_W < 6) begin : g_div_check
        $error("adcc_tad_gen: DIV_W must reach a half period of 32 clocks");
    end

    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] half_len;
    logic use_rc;

    // /2 /4 /8 /16 /32 /64 give half periods of 1 2 4 8 16 32 clocks
    assign half_len = DIV_W'(1) << {clock_sel[1:0], clock_sel[2]};
    assign use_rc = (clock_sel[1:0] == adcc_pkg::CLK_RC_LOW);

    always_ff @(posedge clk) begin
        if (srst || !run) begin
            cnt_q <= '0;
        end else if (!use_rc) begin
            cnt_q <= (cnt_q == half_len - DIV_W'(1)) ? '0 : cnt_q + DIV_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !run) begin
            half_tick <= 1'b0;
        end else if (use_rc) begin
            half_tick <= rc_tick;
        end else begin
            half_tick <= (cnt_q == half_len - DIV_W'(1));
        end
    end
endmodule : adcc_tad_gen
`default_nettype wire

/* logic/adcc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_core (
    input wire logic clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire adcc_pkg::adcc_trig_type trig_in,
    input wire logic rc_tick,
    input wire logic sar_cmp,
    input wire logic sleep_mode,
    output adcc_pkg::adcc_analog_type analog_q,
    output logic conv_irq_q,
    output logic wake_q
);
    adcc_pkg::adcc_state_type state_q;
    logic [7:0] chan_ctl_q, fmt_q, trig_sel_q, res_hi_q, res_lo_q;
    logic done_q, irq_en_q, power_off_q;
    logic [9:0] sar_q;
    logic [3:0] bit_q;
    logic last_q;
    logic [4:0] hcnt_q;
    logic [2:0] dly_q;
    adcc_pkg::adcc_trig_type trig_prev_q;
    logic half_tick, acc, wr, rd, rc_sel, enabled;
    logic sw_start, sw_abort, trig_edge, start, sleep_abort;
    logic resolve, finish, do_abort;
    logic [5:0] rise;
    logic [9:0] final_val, part_val, load_val;
    logic [7:0] wbyte;

    assign acc = (avs_read || avs_write) && !avs_waitrequest;
    assign wr = acc && avs_write && avs_byteenable[0];
    assign rd = avs_read && avs_waitrequest;
    assign wbyte = avs_writedata[7:0];
    assign rc_sel = (fmt_q[adcc_pkg::POS_CLOCK_SEL +: 2] == adcc_pkg::CLK_RC_LOW);
    assign enabled = chan_ctl_q[adcc_pkg::POS_ENABLE] && !power_off_q;

    assign sw_start = wr && avs_address == adcc_pkg::OFS_CHANNEL_CONTROL && wbyte[adcc_pkg::POS_GO_BUSY];
    assign sw_abort = wr && avs_address == adcc_pkg::OFS_CHANNEL_CONTROL && !wbyte[adcc_pkg::POS_GO_BUSY];
    assign rise = trig_in & ~trig_prev_q;
    always_comb begin
        case (trig_sel_q[adcc_pkg::POS_TRIG_SEL +: 4])
            adcc_pkg::TRIG_TIMER_0: trig_edge = rise[5];
            adcc_pkg::TRIG_TIMER_1: trig_edge = rise[4];
            adcc_pkg::TRIG_TIMER_2: trig_edge = rise[3];
            adcc_pkg::TRIG_COMPARATOR_1: trig_edge = rise[2];
            adcc_pkg::TRIG_LOGIC_CELL_1: trig_edge = rise[1];
            adcc_pkg::TRIG_LOGIC_CELL_2: trig_edge = rise[0];
            default: trig_edge = 1'b0;
        endcase
    end
    // start needs the module already enabled
    assign start = (state_q == adcc_pkg::ST_IDLE) && enabled && !sleep_mode && (sw_start || trig_edge);
    assign sleep_abort = sleep_mode && !rc_sel && (state_q != adcc_pkg::ST_IDLE);
    assign resolve = (state_q == adcc_pkg::ST_CONV) && half_tick && !hcnt_q[0]
        && hcnt_q > 5'(adcc_pkg::SETUP_HALF_PERIODS);
    assign finish = resolve && hcnt_q == 5'(adcc_pkg::CONV_HALF_PERIODS - 1);
    assign do_abort = (state_q != adcc_pkg::ST_IDLE) && !finish
        && (sw_abort || !chan_ctl_q[adcc_pkg::POS_ENABLE] || sleep_abort);

    assign final_val = {sar_q[9:1], sar_cmp};
    always_comb begin
        for (int i = 0; i < adcc_pkg::RESULT_BITS; i++) begin
            part_val[i] = (4'(i) <= bit_q) ? last_q : sar_q[i];
        end
    end
    assign load_val = finish ? final_val : part_val;

    adcc_tad_gen #(
        .DIV_W(6)
    ) u_tad (
        .clk(clk),
        .srst(srst),
        .run(state_q == adcc_pkg::ST_CONV),
        .clock_sel(fmt_q[adcc_pkg::POS_CLOCK_SEL +: 3]),
        .rc_tick(rc_tick),
        .half_tick(half_tick)
    );

    // avalon answer: waitrequest drops one cycle after a request, for one cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            avs_readdata <= '0;
        end else if (rd) begin
            case (avs_address)
                adcc_pkg::OFS_CHANNEL_CONTROL: avs_readdata <= {24'h0, 1'b0, chan_ctl_q[6:2],
                    state_q != adcc_pkg::ST_IDLE, chan_ctl_q[0]};
                adcc_pkg::OFS_FORMAT_CLOCK_REF: avs_readdata <= {24'h0, fmt_q};
                adcc_pkg::OFS_TRIGGER_SELECT: avs_readdata <= {24'h0, trig_sel_q};
                adcc_pkg::OFS_RESULT_HIGH: avs_readdata <= {24'h0, res_hi_q};
                adcc_pkg::OFS_RESULT_LOW: avs_readdata <= {24'h0, res_lo_q};
                adcc_pkg::OFS_DONE_STATUS: avs_readdata <= {29'h0, enabled, irq_en_q, done_q};
                default: avs_readdata <= '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            chan_ctl_q <= adcc_pkg::RST_CHANNEL_CONTROL;
            fmt_q <= adcc_pkg::RST_FORMAT_CLOCK_REF;
            trig_sel_q <= adcc_pkg::RST_TRIGGER_SELECT;
            irq_en_q <= 1'b0;
        end else if (wr) begin
            case (avs_address)
                adcc_pkg::OFS_CHANNEL_CONTROL: chan_ctl_q <= {1'b0, wbyte[6:2], 1'b0, wbyte[0]};
                adcc_pkg::OFS_FORMAT_CLOCK_REF: fmt_q <= {wbyte[7:4], 2'b00, wbyte[1:0]};
                adcc_pkg::OFS_TRIGGER_SELECT: trig_sel_q <= {wbyte[7:4], 4'h0};
                adcc_pkg::OFS_DONE_STATUS: irq_en_q <= wbyte[adcc_pkg::POS_IRQ_ENABLE];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            trig_prev_q <= '0;
        end else begin
            trig_prev_q <= trig_in;
        end
    end

    // sequencer
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= adcc_pkg::ST_IDLE;
            dly_q <= '0;
            hcnt_q <= '0;
        end else begin
            case (state_q)
                adcc_pkg::ST_IDLE: begin
                    dly_q <= '0;
                    hcnt_q <= '0;
                    if (start) begin
                        state_q <= rc_sel ? adcc_pkg::ST_DELAY : adcc_pkg::ST_CONV;
                    end
                end
                adcc_pkg::ST_DELAY: begin
                    dly_q <= dly_q + 3'h1;
                    if (do_abort) begin
                        state_q <= adcc_pkg::ST_IDLE;
                    end else if (dly_q == 3'(adcc_pkg::RC_START_DELAY_CLKS - 1)) begin
                        state_q <= adcc_pkg::ST_CONV;
                    end
                end
                adcc_pkg::ST_CONV: begin
                    if (finish || do_abort) begin
                        state_q <= adcc_pkg::ST_IDLE;
                    end else if (half_tick) begin
                        hcnt_q <= hcnt_q + 5'h1;
                    end
                end
                default: state_q <= adcc_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst || state_q == adcc_pkg::ST_IDLE) begin
            sar_q <= '0;
            bit_q <= 4'(adcc_pkg::RESULT_BITS - 1);
            last_q <= 1'b0;
        end else if (resolve) begin
            sar_q[bit_q] <= sar_cmp;
            bit_q <= bit_q - 4'h1;
            last_q <= sar_cmp;
        end
    end

    // result load on completion or on a software abort in ST_CONV
    always_ff @(posedge clk) begin
        if (srst) begin
            res_hi_q <= adcc_pkg::RST_RESULT;
            res_lo_q <= adcc_pkg::RST_RESULT;
        end else if (finish || (do_abort && sw_abort && state_q == adcc_pkg::ST_CONV)) begin
            if (fmt_q[adcc_pkg::POS_JUSTIFY]) begin
                res_hi_q <= {6'h00, load_val[9:8]};
                res_lo_q <= load_val[7:0];
            end else begin
                res_hi_q <= load_val[9:2];
                res_lo_q <= {load_val[1:0], 6'h00};
            end
        end else if (wr && avs_address == adcc_pkg::OFS_RESULT_HIGH) begin
            res_hi_q <= wbyte;
        end else if (wr && avs_address == adcc_pkg::OFS_RESULT_LOW) begin
            res_lo_q <= wbyte;
        end
    end

    // done flag, set wins over write-one-to-clear
    always_ff @(posedge clk) begin
        if (srst) begin
            done_q <= 1'b0;
        end else if (finish) begin
            done_q <= 1'b1;
        end else if (wr && avs_address == adcc_pkg::OFS_DONE_STATUS && wbyte[adcc_pkg::POS_DONE_FLAG]) begin
            done_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !sleep_mode) begin
            power_off_q <= 1'b0;
        end else if (sleep_abort || (finish && !irq_en_q)) begin
            power_off_q <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            conv_irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            conv_irq_q <= done_q && irq_en_q;
            wake_q <= done_q && irq_en_q && sleep_mode;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            analog_q <= '0;
        end else begin
            analog_q.powered <= enabled;
            analog_q.channel <= chan_ctl_q[adcc_pkg::POS_CHANNEL +: 5];
            analog_q.channel_valid <= chan_ctl_q[6:2] <= adcc_pkg::CHAN_LAST_PIN
                || chan_ctl_q[6:2] >= adcc_pkg::CHAN_TEMPERATURE;
            analog_q.ref_ext_pin <= fmt_q[adcc_pkg::POS_POS_REF +: 2] == adcc_pkg::PREF_EXT_PIN;
            analog_q.sampling <= enabled && state_q != adcc_pkg::ST_CONV;
            analog_q.trial <= (state_q == adcc_pkg::ST_CONV) ? (sar_q | (10'h001 << bit_q)) : 10'h000;
        end
    end

    a_finish_clears: assert property (@(posedge clk) disable iff (srst)
        finish |=> state_q == adcc_pkg::ST_IDLE && done_q)
        else $error("completion did not clear busy and set flag");
    a_disabled_idle: assert property (@(posedge clk) disable iff (srst)
        !chan_ctl_q[0] |=> state_q == adcc_pkg::ST_IDLE)
        else $error("conversion running while disabled");
    a_start_busy: assert property (@(posedge clk) disable iff (srst)
        start && !rc_sel |=> state_q == adcc_pkg::ST_CONV)
        else $error("start did not raise busy");
    a_rc_delay: assert property (@(posedge clk) disable iff (srst)
        start && rc_sel && !sleep_abort |=> state_q == adcc_pkg::ST_DELAY [*4])
        else $error("rc start delay wrong");
    a_sleep_abort: assert property (@(posedge clk) disable iff (srst)
        sleep_abort |=> state_q == adcc_pkg::ST_IDLE && (power_off_q || !sleep_mode) && chan_ctl_q[0])
        else $error("sleep abort misbehaved");
    a_left_format: assert property (@(posedge clk) disable iff (srst)
        finish && !fmt_q[7] |=> res_hi_q == $past(final_val[9:2]) && res_lo_q[5:0] == 6'h00)
        else $error("left justified result wrong");
    a_right_format: assert property (@(posedge clk) disable iff (srst)
        finish && fmt_q[7] |=> res_lo_q == $past(final_val[7:0]) && res_hi_q[7:2] == 6'h00)
        else $error("right justified result wrong");
    a_flag_sticky: assert property (@(posedge clk) disable iff (srst)
        done_q && !wr |=> done_q)
        else $error("done flag cleared itself");
    a_trig_start: assert property (@(posedge clk) disable iff (srst)
        trig_edge && state_q == adcc_pkg::ST_IDLE && enabled && !sleep_mode |=> state_q != adcc_pkg::ST_IDLE)
        else $error("trigger edge did not start");
    a_bit_count: assert property (@(posedge clk) disable iff (srst)
        finish |-> bit_q == 4'h0)
        else $error("conversion ended with bits left");
    c_complete: cover property (@(posedge clk) disable iff (srst) finish);
    c_sw_abort: cover property (@(posedge clk) disable iff (srst) do_abort && sw_abort);
    c_trigger: cover property (@(posedge clk) disable iff (srst) start && trig_edge);
    c_sleep_done: cover property (@(posedge clk) disable iff (srst) finish && sleep_mode && rc_sel);
endmodule : adcc_core
`default_nettype wire

/* test/adc_conversion_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    adcc_pkg::adcc_trig_type trig_in = '0;
    logic rc_tick = 1'h0;
    logic sar_cmp;
    logic sleep_mode = 1'h0;
    adcc_pkg::adcc_analog_type analog_q;
    logic conv_irq_q;
    logic wake_q;
    logic [9:0] target = 10'h000;
    logic [9:0] part;
    logic [32:0] exp_q[$];
    logic [32:0] note;
    logic [2:0] cs_tab[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int hp_tab[8] = '{1, 2, 4, 8, 16, 32, 6, 6};
    logic [3:0] trg_tab[7] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'h0};
    logic [4:0] ch_tab[7] = '{5'h00, 5'h03, 5'h04, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
    int n_mismatch = 0;
    int n_compared = 0;
    int n;
    int rc_cnt = 0;

    adcc_core adcc_core_inst (.clk(clk), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trig_in(trig_in),
        .rc_tick(rc_tick), .sar_cmp(sar_cmp), .sleep_mode(sleep_mode), .analog_q(analog_q),
        .conv_irq_q(conv_irq_q), .wake_q(wake_q));

    always #25 clk = ~clk;
    // comparator model: keep the trial bit while the trial code does not exceed the input
    assign sar_cmp = (analog_q.trial <= target);

    // rc clock half period is six system clocks
    always @(posedge clk) begin
        rc_cnt <= (rc_cnt == 5) ? 0 : rc_cnt + 1;
        rc_tick <= (rc_cnt == 5);
    end

    task automatic compare(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : compare

    // read data are taken at the rising edge where waitrequest is sampled low
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'h0) begin
            note = exp_q.pop_front();
            if (note[32]) begin
                compare(avs_readdata, note[31:0]);
            end
        end
    end

    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_read <= ~wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= 4'h1;
        @(posedge clk);
        while (avs_waitrequest !== 1'h0 && k < 20) begin
            @(posedge clk);
            k++;
        end
        if (k == 20) begin
            n_mismatch++;
            $display("BAD %0t no bus answer", $time);
        end
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge clk);
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'h1, a, d);
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        exp_q.push_back({1'h1, 24'h0, e});
        bus(1'h0, a, 8'h00);
    endtask : rd

    task automatic rdx(input logic [4:0] a);
        exp_q.push_back(33'h0);
        bus(1'h0, a, 8'h00);
    endtask : rdx

    task automatic settle(input int c);
        repeat (c) @(negedge clk);
        @(posedge clk);
    endtask : settle

    // start with the given format byte, count clocks until the done interrupt shows
    task automatic timed(input logic [7:0] fmt, output int c);
        wr(adcc_pkg::OFS_FORMAT_CLOCK_REF, fmt);
        settle(4);
        wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h03);
        c = 0;
        @(negedge clk);
        while (conv_irq_q !== 1'h1 && c < 3000) begin
            @(negedge clk);
            c++;
        end
        @(posedge clk);
    endtask : timed

    task automatic final_report;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        $display("BAD %0t watchdog expired", $time);
        final_report;
    end

    initial begin
        void'($urandom(32'h6118));
        repeat (3) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) rd(5'(4 * i), 8'h00);
        wr(5'h18, 8'hff);
        rd(5'h18, 8'h00);
        // start in the enabling write is ignored
        wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h03);
        rd(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h01);
        compare(analog_q.powered, 1'h1);
        wr(adcc_pkg::OFS_RESULT_HIGH, 8'ha5);
        wr(adcc_pkg::OFS_RESULT_LOW, 8'h5a);
        rd(adcc_pkg::OFS_RESULT_HIGH, 8'ha5);
        rd(adcc_pkg::OFS_RESULT_LOW, 8'h5a);
        $display("test registers done");
        for (int i = 0; i < 7; i++) begin
            wr(adcc_pkg::OFS_CHANNEL_CONTROL, {1'h0, ch_tab[i], 2'h1});
            settle(1);
            compare(analog_q.channel_valid, (ch_tab[i] <= 5'h03) || (ch_tab[i] >= 5'h1d));
        end
        wr(adcc_pkg::OFS_FORMAT_CLOCK_REF, 8'h02);
        settle(1);
        compare(analog_q.ref_ext_pin, 1'h1);
        wr(adcc_pkg::OFS_FORMAT_CLOCK_REF, 8'h00);
        settle(1);
        compare(analog_q.ref_ext_pin, 1'h0);
        wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h01);
        $display("test decode done");
        // conversion length per clock code, right justified result
        wr(adcc_pkg::OFS_DONE_STATUS, 8'h03);
        for (int i = 0; i < 8; i++) begin
            target <= 10'($urandom);
            timed({1'h1, cs_tab[i], 4'h0}, n);
            compare(n >= ((i < 6) ? 23 * hp_tab[i] - 2 : 4 + 22 * 6) && n <= 23 * hp_tab[i] + 12, 1'h1);
            rd(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h01);
            if (i >= 2) begin
                rd(adcc_pkg::OFS_RESULT_HIGH, {6'h00, target[9:8]});
                rd(adcc_pkg::OFS_RESULT_LOW, target[7:0]);
            end
            settle(20);
            compare(conv_irq_q, 1'h1);
            wr(adcc_pkg::OFS_DONE_STATUS, 8'h03);
            settle(1);
            compare(conv_irq_q, 1'h0);
        end
        target <= 10'($urandom);
        timed({1'h0, 3'h5, 4'h0}, n);
        rd(adcc_pkg::OFS_RESULT_HIGH, target[9:2]);
        rd(adcc_pkg::OFS_RESULT_LOW, {target[1:0], 6'h00});
        wr(adcc_pkg::OFS_DONE_STATUS, 8'h03);
        $display("test conversion done");
        // abort after four resolved bits fills the rest with the last bit
        target <= 10'($urandom);
        wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h03);
        rd(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h03);
        repeat (91) @(posedge clk);
        wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h01);
        part = {target[9:6], {6{target[6]}}};
        rd(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h01);
        rd(adcc_pkg::OFS_RESULT_HIGH, part[9:2]);
        rd(adcc_pkg::OFS_RESULT_LOW, {part[1:0], 6'h00});
        $display("test abort done");
        // each trigger code starts on its own source only
        for (int j = 0; j < 7; j++) begin
            wr(adcc_pkg::OFS_TRIGGER_SELECT, {trg_tab[j], 4'h0});
            trig_in <= (j < 6) ? adcc_pkg::adcc_trig_type'(6'h20 >> ((j + 1) % 6)) : '1;
            @(posedge clk);
            trig_in <= '0;
            settle(2);
            rd(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h01);
            if (j < 6) begin
                trig_in <= adcc_pkg::adcc_trig_type'(6'h20 >> j);
                settle(2);
                rd(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h03);
                trig_in <= '0;
                wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h01);
            end
        end
        wr(adcc_pkg::OFS_TRIGGER_SELECT, 8'h00);
        wr(adcc_pkg::OFS_DONE_STATUS, 8'h03);
        $display("test trigger done");
        // sleep with a divided clock aborts and powers off
        wr(adcc_pkg::OFS_FORMAT_CLOCK_REF, 8'hd0);
        wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h03);
        settle(40);
        sleep_mode <= 1'h1;
        settle(10);
        compare(analog_q.powered, 1'h0);
        rd(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h01);
        sleep_mode <= 1'h0;
        // rc conversion runs on in sleep and wakes with the interrupt enabled
        wr(adcc_pkg::OFS_FORMAT_CLOCK_REF, 8'hb0);
        wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h03);
        sleep_mode <= 1'h1;
        n = 0;
        while (wake_q !== 1'h1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        compare(wake_q, 1'h1);
        @(posedge clk);
        sleep_mode <= 1'h0;
        // without the interrupt the converter powers itself off, enable stays
        wr(adcc_pkg::OFS_DONE_STATUS, 8'h01);
        wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h03);
        sleep_mode <= 1'h1;
        settle(250);
        compare(analog_q.powered, 1'h0);
        rd(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h01);
        rd(adcc_pkg::OFS_DONE_STATUS, 8'h01);
        sleep_mode <= 1'h0;
        $display("test sleep done");
        wr(adcc_pkg::OFS_FORMAT_CLOCK_REF, 8'he0);
        wr(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h03);
        settle(50);
        srst <= 1'h1;
        repeat (3) @(posedge clk);
        compare(32'(analog_q), 32'h0);
        compare(avs_waitrequest, 1'h1);
        srst <= 1'h0;
        @(posedge clk);
        rd(adcc_pkg::OFS_CHANNEL_CONTROL, 8'h00);
        rd(adcc_pkg::OFS_FORMAT_CLOCK_REF, 8'h00);
        $display("test reset done");
        final_report;
    end
endmodule : adc_conversion_control_tb
`default_nettype wire
